// ==== src/ivm_vector_map.sv ====
// Vector address generator with boot relocation and change window.
`timescale 1ns/1ps
module ivm_vector_map (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Fuse and boot section start
  input  wire logic                       boot_reset_fuse,
  input  wire logic [ivm_pkg::ADDR_W-1:0] boot_reset_addr,
  // Core control register write port
  input  wire logic                       ctrl_wr,
  input  wire logic                       ctrl_wr_select,
  input  wire logic                       ctrl_wr_change_en,
  // Requests from peripherals, bit i is vector number i+2
  input  wire logic [ivm_pkg::NUM_SRC-1:0] irq_req,
  // Core side
  input  wire logic                       global_irq_en,
  input  wire logic                       instr_retire,
  input  wire logic                       vec_ack,
  output logic      [ivm_pkg::ADDR_W-1:0] reset_addr_q,
  output logic                            vector_select_q,
  output logic                            change_enable_q,
  output logic                            irq_blocked_q,
  output logic                            vec_valid_q,
  output logic      [ivm_pkg::NUM_W-1:0]  vec_num_q,
  output logic      [ivm_pkg::ADDR_W-1:0] vec_addr_q
);

  logic                        fuse_q;
  logic [ivm_pkg::ADDR_W-1:0]  boot_addr_q;
  logic [1:0]                  ce_cnt_q;
  ivm_pkg::ivm_blk_type        blk_q;
  ivm_pkg::ivm_blk_type        blk_d;
  logic                        ce_set;
  logic                        sel_wr;
  logic                        ce_expire;
  logic                        blocked_now;
  logic [ivm_pkg::NUM_SRC:0]   lower_pend;
  logic [ivm_pkg::NUM_SRC-1:0] grant;
  logic [ivm_pkg::NUM_W-1:0]   win_num;
  logic [ivm_pkg::ADDR_W-1:0]  table_org;
  logic [ivm_pkg::ADDR_W-1:0]  win_addr;
  logic                        issue;

  // Fuse and boot start are caught while reset is held; they are static.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fuse_q <= boot_reset_fuse;
      boot_addr_q <= boot_reset_addr;
    end
  end

  // One reset entry for every cause, chosen only by the fuse.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      if (boot_reset_fuse) begin // RULE18
        reset_addr_q <= ivm_pkg::RESET_ADDR_APP; // RULE1
      end else begin
        reset_addr_q <= boot_reset_addr; // RULE15
      end
    end
  end

  assign ce_set = ctrl_wr && ctrl_wr_change_en;
  // A write with enable low while the window is open is the select write.
  assign sel_wr = ctrl_wr && !ctrl_wr_change_en && change_enable_q; // RULE19
  assign ce_expire = change_enable_q && (ce_cnt_q == ivm_pkg::CHG_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_select_q <= 1'b0;
    end else if (sel_wr) begin
      vector_select_q <= ctrl_wr_select; // RULE19
    end
  end

  // A fresh enable write restarts the window rather than extending it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      change_enable_q <= 1'b0;
      ce_cnt_q <= ivm_pkg::CHG_CNT_RST;
    end else if (ce_set) begin
      change_enable_q <= 1'b1;
      ce_cnt_q <= ivm_pkg::CHG_CNT_RST;
    end else if (sel_wr || ce_expire) begin
      change_enable_q <= 1'b0; // RULE20
      ce_cnt_q <= ivm_pkg::CHG_CNT_RST;
    end else if (change_enable_q) begin
      ce_cnt_q <= ce_cnt_q + 2'h1;
    end
  end

  // Dispatch blocking; the core's global enable is never touched here.
  always_comb begin
    blk_d = blk_q;
    case (blk_q)
      ivm_pkg::BLK_IDLE: begin
        if (ce_set) begin
          blk_d = ivm_pkg::BLK_WINDOW; // RULE21
        end
      end
      ivm_pkg::BLK_WINDOW: begin
        if (ce_set) begin
          blk_d = ivm_pkg::BLK_WINDOW;
        end else if (sel_wr) begin
          blk_d = ivm_pkg::BLK_INSTR;
        end else if (ce_expire) begin
          blk_d = ivm_pkg::BLK_IDLE; // RULE21
        end
      end
      ivm_pkg::BLK_INSTR: begin
        if (ce_set) begin
          blk_d = ivm_pkg::BLK_WINDOW;
        end else if (instr_retire) begin
          blk_d = ivm_pkg::BLK_IDLE; // RULE21
        end
      end
      default: begin
        blk_d = ivm_pkg::BLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      blk_q <= ivm_pkg::BLK_IDLE;
      irq_blocked_q <= 1'b0;
    end else begin
      blk_q <= blk_d;
      irq_blocked_q <= (blk_d != ivm_pkg::BLK_IDLE);
    end
  end

  // The enable write cycle itself is already blocked.
  assign blocked_now = ce_set || (blk_q != ivm_pkg::BLK_IDLE); // RULE21

  // Lowest pending vector number wins.
  assign lower_pend[0] = 1'b0;
  for (genvar i = 0; i < ivm_pkg::NUM_SRC; i++) begin : g_pri
    assign grant[i] = irq_req[i] && !lower_pend[i]; // RULE23
    assign lower_pend[i+1] = lower_pend[i] || irq_req[i];
  end

  always_comb begin
    win_num = ivm_pkg::VEC_NUM_NONE;
    for (int k = 0; k < ivm_pkg::NUM_SRC; k++) begin
      if (grant[k]) begin
        win_num = ivm_pkg::VEC_NUM_FIRST + ivm_pkg::NUM_W'(k);
      end
    end
  end

  // Slot n sits at origin + 2*(n-1); origin moves to the boot section.
  assign table_org = vector_select_q ? boot_addr_q
                                     : ivm_pkg::TABLE_ORG_APP; // RULE16 RULE17
  // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
  // RULE13 RULE14 follow from the slot formula on the source ordering.
  assign win_addr = table_org
                  + ivm_pkg::ADDR_W'({win_num - 6'h01, 1'b0}); // RULE22

  assign issue = !vec_valid_q && lower_pend[ivm_pkg::NUM_SRC]
              && global_irq_en && !blocked_now;

  // The vector stands until the core takes it, so the address cannot slip.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_valid_q <= 1'b0;
      vec_num_q <= ivm_pkg::VEC_NUM_NONE;
      vec_addr_q <= ivm_pkg::RESET_ADDR_APP;
    end else if (issue) begin
      vec_valid_q <= 1'b1;
      vec_num_q <= win_num;
      vec_addr_q <= win_addr;
    end else if (vec_ack) begin
      vec_valid_q <= 1'b0;
    end
  end

  // Helper for the assertions below.
  logic [ivm_pkg::NUM_SRC-1:0] low_mask;
  logic [ivm_pkg::ADDR_W-1:0]  slot_off;
  assign low_mask = (ivm_pkg::NUM_SRC'(1) << (vec_num_q - 6'h02))
                  - ivm_pkg::NUM_SRC'(1);
  assign slot_off = ivm_pkg::ADDR_W'({vec_num_q, 1'b0});

  a_reset_app_entry: // RULE1
    assert property (@(posedge core_clk)
      $fell(rst) && fuse_q |-> reset_addr_q == 16'h0000)
    else $error("reset entry not zero with fuse unprogrammed");

  a_reset_boot_entry: // RULE15
    assert property (@(posedge core_clk) disable iff (rst)
      !fuse_q |-> reset_addr_q == boot_addr_q)
    else $error("reset entry not boot address with fuse programmed");

  a_ext_slots: // RULE2
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      && vec_num_q inside {[2:4]}
      |-> vec_addr_q == ivm_pkg::ADDR_EXT0 + slot_off - 16'h0004)
    else $error("external request slot wrong");

  a_pin_slots: // RULE3
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h05 -> vec_addr_q == ivm_pkg::ADDR_PCG0)
       && (vec_num_q == 6'h08 -> vec_addr_q == 16'h000E)
       && (vec_num_q == 6'h26 -> vec_addr_q == ivm_pkg::ADDR_PCG4))
    else $error("pin change slot wrong");

  a_t2_slots: // RULE4
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h0A -> vec_addr_q == 16'h0012)
       && (vec_num_q == 6'h0B -> vec_addr_q == 16'h0014)
       && (vec_num_q == 6'h0C -> vec_addr_q == 16'h0016))
    else $error("timer two slot wrong");

  a_t1_end: // RULE5
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      && vec_num_q == 6'h10
      |-> vec_addr_q == 16'h001E)
    else $error("timer one overflow slot wrong");

  a_t0_slots: // RULE6
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h11 -> vec_addr_q == 16'h0020)
       && (vec_num_q == 6'h12 -> vec_addr_q == 16'h0022)
       && (vec_num_q == 6'h13 -> vec_addr_q == 16'h0024))
    else $error("timer zero slot wrong");

  a_t3_end: // RULE7
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      && vec_num_q == 6'h23
      |-> vec_addr_q == 16'h0044)
    else $error("timer three overflow slot wrong");

  a_t4_end: // RULE8
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      && vec_num_q == 6'h2F
      |-> vec_addr_q == 16'h005C)
    else $error("timer four overflow slot wrong");

  a_port0_slots: // RULE9
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h15 -> vec_addr_q == 16'h0028)
       && (vec_num_q == 6'h16 -> vec_addr_q == 16'h002A)
       && (vec_num_q == 6'h17 -> vec_addr_q == 16'h002C)
       && (vec_num_q == 6'h24 -> vec_addr_q == 16'h0046))
    else $error("async port zero slot wrong");

  a_port1_slots: // RULE10
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h1D -> vec_addr_q == 16'h0038)
       && (vec_num_q == 6'h1F -> vec_addr_q == 16'h003C)
       && (vec_num_q == 6'h25 -> vec_addr_q == 16'h0048))
    else $error("async port one slot wrong");

  a_port2_end: // RULE11
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      && vec_num_q == 6'h33
      |-> vec_addr_q == 16'h0064)
    else $error("async port two frame start slot wrong");

  a_link_slots: // RULE12
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h14 -> vec_addr_q == 16'h0026)
       && (vec_num_q == 6'h2A -> vec_addr_q == 16'h0052)
       && (vec_num_q == 6'h1B -> vec_addr_q == 16'h0034)
       && (vec_num_q == 6'h2B -> vec_addr_q == 16'h0054))
    else $error("serial or two-wire slot wrong");

  a_misc_slots: // RULE13
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h18 -> vec_addr_q == 16'h002E)
       && (vec_num_q == 6'h19 -> vec_addr_q == 16'h0030)
       && (vec_num_q == 6'h1A -> vec_addr_q == 16'h0032)
       && (vec_num_q == 6'h1C -> vec_addr_q == 16'h0036))
    else $error("comparator converter or store slot wrong");

  a_crystal_slots: // RULE14
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h27 -> vec_addr_q == 16'h004C)
       && (vec_num_q == 6'h29 -> vec_addr_q == 16'h0050))
    else $error("crystal or touch window slot wrong");

  a_vector_stands: // RULE22
    assert property (@(posedge core_clk) disable iff (rst)
      vec_valid_q && !vec_ack
      |=> vec_valid_q && $stable(vec_addr_q) && $stable(vec_num_q))
    else $error("vector changed before the core took it");

  a_timer_slots: // RULE4
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h09 -> vec_addr_q == ivm_pkg::ADDR_WDOG)
       && (vec_num_q == 6'h0D -> vec_addr_q == ivm_pkg::ADDR_T1CAP)
       && (vec_num_q == 6'h20 -> vec_addr_q == ivm_pkg::ADDR_T3CAP)
       && (vec_num_q == 6'h2C -> vec_addr_q == ivm_pkg::ADDR_T4CAP))
    else $error("timer slot wrong");

  a_port_slots: // RULE11
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) && !$past(vector_select_q)
      |-> (vec_num_q == 6'h30 -> vec_addr_q == ivm_pkg::ADDR_A2RX)
       && (vec_num_q == 6'h28 -> vec_addr_q == ivm_pkg::ADDR_TOUCH))
    else $error("serial or touch slot wrong");

  a_relocated_slot: // RULE16
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q)
      |-> vec_addr_q == ($past(vector_select_q) ? boot_addr_q : 16'h0000)
                       + slot_off - 16'h0002)
    else $error("vector address not origin plus slot");

  a_select_guarded: // RULE19
    assert property (@(posedge core_clk) disable iff (rst)
      $changed(vector_select_q)
      |-> $past(change_enable_q) && $past(ctrl_wr)
       && !$past(ctrl_wr_change_en))
    else $error("select changed outside the change window");

  a_enable_expiry: // RULE20
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(change_enable_q) ##1 !ctrl_wr [*3]
      |=> !change_enable_q)
    else $error("change enable not cleared after four cycles");

  a_block_dispatch: // RULE21
    assert property (@(posedge core_clk) disable iff (rst)
      ce_set |=> irq_blocked_q && !$rose(vec_valid_q))
    else $error("dispatch not blocked by change enable");

  a_lowest_first: // RULE23
    assert property (@(posedge core_clk) disable iff (rst)
      $rose(vec_valid_q) |-> ($past(irq_req) & low_mask) == '0)
    else $error("lower pending vector skipped");

endmodule

// ==== src/ivm_pkg.sv ====
// Constants for the reset and interrupt vector address map.
// Functional notes
// RULE1 - Every reset cause uses one reset vector, at 0x0000 with fuse unprogrammed.
// RULE2 - External requests 0, 1, 2 vector to 0x0002, 0x0004, 0x0006.
// RULE3 - Pin change groups 0-3 use 0x0008-0x000E; group 4 uses 0x004A.
// RULE4 - Watchdog at 0x0010; timer 2 match A, B, overflow at 0x0012-0x0016.
// RULE5 - Timer 1 capture, match A, B, overflow occupy 0x0018 to 0x001E.
// RULE6 - Timer 0 match A, match B, overflow use 0x0020, 0x0022, 0x0024.
// RULE7 - Timer 3 capture, match A, B, overflow occupy 0x003E to 0x0044.
// RULE8 - Timer 4 capture, match A, B, overflow occupy 0x0056 to 0x005C.
// RULE9 - Async port 0 rx, empty, tx at 0x0028-0x002C; frame start 0x0046.
// RULE10 - Async port 1 rx, empty, tx at 0x0038-0x003C; frame start 0x0048.
// RULE11 - Async port 2 rx, empty, tx, frame start occupy 0x005E to 0x0064.
// RULE12 - Serial periph 0/1 at 0x0026/0x0052; two-wire 0/1 at 0x0034/0x0054.
// RULE13 - Comparator 0x002E, converter 0x0030, eeprom 0x0032, self-program 0x0036.
// RULE14 - Crystal failure 0x004C; touch conversion 0x004E, touch window 0x0050.
// RULE15 - Programmed boot fuse starts execution at the boot reset address.
// RULE16 - Select bit set adds boot section start to every vector address.
// RULE17 - Table starts at 0x0002, or boot address plus 0x0002 when selected.
// RULE18 - Fuse value 1 means unprogrammed, reset zero; 0 means boot address.
// RULE19 - Select changes only by enable write, then select write within four cycles.
// RULE20 - Change enable clears four cycles after its write, or on select write.
// RULE21 - Dispatch blocked from enable write until after next instruction or four cycles.
// RULE22 - Vector address is table origin plus two times vector number minus one.
// RULE23 - Among pending requests the lowest vector number is dispatched first.
package ivm_pkg;

  localparam int ADDR_W = 16;
  localparam int NUM_W = 6;
  localparam int NUM_SRC = 50;

  localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 16'h0000;
  localparam logic [ADDR_W-1:0] TABLE_ORG_APP = 16'h0000;
  localparam logic [NUM_W-1:0] VEC_NUM_FIRST = 6'h02;
  localparam logic [NUM_W-1:0] VEC_NUM_NONE = 6'h00;

  // Anchor addresses of the base table, with select clear.
  localparam logic [ADDR_W-1:0] ADDR_EXT0 = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_PCG0 = 16'h0008;
  localparam logic [ADDR_W-1:0] ADDR_PCG4 = 16'h004A;
  localparam logic [ADDR_W-1:0] ADDR_WDOG = 16'h0010;
  localparam logic [ADDR_W-1:0] ADDR_T1CAP = 16'h0018;
  localparam logic [ADDR_W-1:0] ADDR_T3CAP = 16'h003E;
  localparam logic [ADDR_W-1:0] ADDR_T4CAP = 16'h0056;
  localparam logic [ADDR_W-1:0] ADDR_A2RX = 16'h005E;
  localparam logic [ADDR_W-1:0] ADDR_TOUCH = 16'h004E;

  localparam int CHG_WINDOW_CYC = 4;
  localparam logic [1:0] CHG_LAST = 2'(CHG_WINDOW_CYC - 1);
  localparam logic [1:0] CHG_CNT_RST = 2'h0;

  typedef enum logic [1:0] {
    BLK_IDLE,
    BLK_WINDOW,
    BLK_INSTR
  } ivm_blk_type;

endpackage

// ==== tb/ivm_core_model.sv ====
// Core model that takes each presented vector after a chosen delay.
`timescale 1ns/1ps
module ivm_core_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Vector handshake
  input  wire logic       vec_valid_q,
  input  wire logic [1:0] ack_delay,
  output logic            vec_ack
);
  logic [1:0] wait_q;

  // A slow core leaves the vector standing for several cycles.
  always_ff @(posedge core_clk) begin
    if (rst || !vec_valid_q || vec_ack) begin
      wait_q  <= 2'h0;
      vec_ack <= 1'b0;
    end else if (wait_q == ack_delay) begin
      vec_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the vector address map.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [ivm_pkg::NUM_W-1:0]  num;
    logic [ivm_pkg::ADDR_W-1:0] addr;
  } ivm_exp_type;
  logic core_clk, rst, fuse, wr, wr_sel, wr_ce, gie, retire, ack;
  logic sel_q, ce_q, blk_q, valid;
  logic seen = 1'b0;
  logic [ivm_pkg::ADDR_W-1:0]  boot, reset_addr, vaddr;
  logic [ivm_pkg::NUM_SRC-1:0] req, r;
  logic [ivm_pkg::NUM_W-1:0]   vnum;
  logic [1:0]                  dly;
  ivm_exp_type                 exp_q[$];
  ivm_exp_type                 m;
  int                          err_total, n_tests, k;

  ivm_vector_map u_ivm_vector_map (
    .core_clk(core_clk), .rst(rst), .boot_reset_fuse(fuse),
    .boot_reset_addr(boot), .ctrl_wr(wr), .ctrl_wr_select(wr_sel),
    .ctrl_wr_change_en(wr_ce), .irq_req(req), .global_irq_en(gie),
    .instr_retire(retire), .vec_ack(ack), .reset_addr_q(reset_addr),
    .vector_select_q(sel_q), .change_enable_q(ce_q),
    .irq_blocked_q(blk_q), .vec_valid_q(valid), .vec_num_q(vnum),
    .vec_addr_q(vaddr)
  );
  ivm_core_model u_ivm_core_model (
    .core_clk(core_clk), .rst(rst), .vec_valid_q(valid),
    .ack_delay(dly), .vec_ack(ack)
  );

  task automatic chk(logic [15:0] got, logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %0t saw %h expected %h", $time, got, want);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_ctrl(logic s, logic c);
    @(posedge core_clk);
    wr <= 1'b1;
    wr_sel <= s;
    wr_ce <= c;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // Holds the request until presented; the source must not drop it early.
  task automatic raise(logic [49:0] rq, int num, logic [15:0] base);
    int i;
    m.num = 6'(num);
    m.addr = base + 16'(2 * (num - 1));
    exp_q.push_back(m);
    @(posedge core_clk);
    req <= rq;
    dly <= 2'($urandom_range(0, 3));
    i = 0;
    do @(posedge core_clk); while (valid !== 1'b1 && ++i < 40);
    req <= '0;
    i = 0;
    do @(posedge core_clk); while (valid !== 1'b0 && ++i < 40);
    chk(16'(i < 40), 16'h0001);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
  // Every newly presented vector is matched against the oldest note.
  always @(posedge core_clk) begin
    if (valid === 1'b1 && !seen) begin
      if (exp_q.size() == 0) begin
        chk(16'(valid), 16'h0000);
      end else begin
        m = exp_q.pop_front();
        chk(16'(vnum), 16'(m.num));
        chk(vaddr, m.addr);
      end
    end
    seen <= (valid === 1'b1);
  end

  initial begin
    void'($urandom(32'h1DA3B499));
    {wr, wr_sel, wr_ce, retire, req, dly} = '0;
    fuse = 1'b1;
    gie = 1'b1;
    boot = 16'h0000;
    rst = 1'b1;
    cyc(3);
    rst <= 1'b0;
    chk(reset_addr, 16'h0000);
    for (int j = 0; j < ivm_pkg::NUM_SRC; j++) begin
      raise(50'(1) << j, j + 2, 16'h0000);
    end
    for (int n = 0; n < 16; n++) begin
      k = $urandom_range(0, 49);
      r = (50'({$urandom, $urandom}) << k) | (50'(1) << k);
      raise(r, k + 2, 16'h0000);
    end
    // With the global flag low a request must wait.
    gie <= 1'b0;
    req <= 50'h2;
    cyc(3);
    chk(16'(valid), 16'h0000);
    gie <= 1'b1;
    raise(50'h2, 3, 16'h0000);
    // Enable without a select write: window and block both lapse.
    wr_ctrl(1'b0, 1'b1);
    req <= 50'h1;
    cyc(4);
    chk(16'(ce_q), 16'h0001);
    chk(16'(valid), 16'h0000);
    cyc(1);
    chk(16'(ce_q), 16'h0000);
    chk(16'(blk_q), 16'h0000);
    raise(50'h1, 2, 16'h0000);
    wr_ctrl(1'b1, 1'b0);
    cyc(1);
    chk(16'(sel_q), 16'h0000);
    boot <= 16'($urandom) & 16'hFFFE;
    fuse <= 1'b0;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    chk(reset_addr, boot);
    k = $urandom_range(0, 49);
    wr_ctrl(1'b0, 1'b1);
    wr_ctrl(1'b1, 1'b0);
    req <= 50'(1) << k;
    cyc(1);
    chk(16'(sel_q), 16'h0001);
    chk(16'(ce_q), 16'h0000);
    cyc(3);
    chk(16'(valid), 16'h0000);
    retire <= 1'b1;
    cyc(1);
    retire <= 1'b0;
    raise(50'(1) << k, k + 2, boot);
    raise(50'h1, 2, boot);
    stop_test();
  end
endmodule
